// File: sgesc_pkg.sv
`default_nettype none
package sgesc_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int GEAR_W = 30;
    localparam int RES_W = 21;
    localparam int FREQ_W = 24;
    localparam int LINE_W = 21;
    localparam int DEV_W = 32;
    localparam int AN_W = 16;
    localparam int SPD_W = 16;
    // ----------------------------------------
    // Scaling and defaults
    // ----------------------------------------
    localparam logic [RES_W-1:0] CMD_PER_REV_DEF = 21'h002710;
    localparam logic [5:0] SEC_PER_MIN = 6'h3c;
    localparam logic [1:0] MODE_SPEED = 2'h1;
    localparam logic [2:0] SPEED_SRC_DEF = 3'h0;
    localparam logic [11:0] GAIN_MIN = 12'h00a;
    localparam logic [11:0] GAIN_MAX = 12'hbb8;
    localparam logic [11:0] GAIN_DEF = 12'h12c;
    localparam logic [13:0] DEAD_MAX = 14'h32c8;
    localparam logic [13:0] DEAD_DEF = 14'h0000;
    localparam logic signed [15:0] OFFS_MAX = 16'sh3a98;
    localparam logic signed [15:0] OFFS_DEF = 16'sh0000;
    localparam logic [12:0] TC_MIN = 13'h0014;
    localparam logic [12:0] TC_MAX = 13'h1388;
    localparam logic [12:0] TC_DEF = 13'h00c8;
    localparam logic [3:0] TENTHS_PER_MV = 4'ha;
    localparam logic [31:0] TENTHS_PER_V = 32'h00002710;
    localparam logic [1:0] INHIBIT_IGNORE_ALL = 2'h3;
    localparam logic [7:0] DRIVE_ENABLE_IN_FUNC = 8'h01;
    localparam logic [7:0] SERVO_READY_OUT_FUNC = 8'h01;
    localparam logic [7:0] POSITION_DONE_OUT_FUNC = 8'h05;
    localparam logic [7:0] POSITION_NEAR_OUT_FUNC = 8'h06;
    localparam logic [3:0] Z_EDGES_NARROW = 4'h2;
    localparam logic [3:0] Z_EDGES_WIDE = 4'h8;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 8;
    localparam int FILT_TICK_NS = 10000;
    localparam int FILT_TICK_CYC = FILT_TICK_NS / CLK_NS;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SRC_ANALOG = 3'h0, SRC_INTERNAL = 3'h1, SRC_MIXED = 3'h2,
        SRC_JOG = 3'h3, SRC_RESERVED = 3'h4, SRC_DEMO = 3'h5
    } sgesc_src_type;
    typedef enum logic [1:0] {
        FS_IDLE = 2'b00, FS_FILT = 2'b01, FS_GAIN = 2'b11
    } sgesc_fstate_type;
    typedef struct packed {
        logic [GEAR_W-1:0] num;
        logic [GEAR_W-1:0] den;
    } sgesc_gear_type;
    typedef struct packed {
        logic [DEV_W-1:0] thr;
        logic [15:0] hyst;
    } sgesc_cmp_type;
    typedef struct packed {
        logic [LINE_W-1:0] lines;
        logic b_rev;
        logic z_rev;
        logic z_wide;
    } sgesc_enc_type;
    typedef struct packed {
        logic chan_sel;
        logic [11:0] gain;
        logic [13:0] dead;
        logic signed [15:0] offs;
        logic [12:0] tc;
    } sgesc_an_type;
endpackage
`default_nettype wire

// File: sgesc_core.sv
// Behaviour
// [RL1] Revolutions equal pulses N over Pt M
// [RL2] Rpm equals 60 f N over Pt M
// [RL3] Encoder output runs at four times line count
// [RL4] B phase setting: 0 forward, 1 reversed
// [RL5] Index phase setting: 0 forward, 1 reversed
// [RL6] Index width one or four A widths
// [RL7] Done output when deviation below threshold, hysteresis
// [RL8] Near output on second threshold, own hysteresis
// [RL9] Control mode 1 selects speed control
// [RL10] Speed source 0 to 5, default analog
// [RL11] Channel select 0: A speed, B torque
// [RL12] Analog gain 10 to 3000, default 300
// [RL13] Dead zone 0 to 13000 mV, default 0
// [RL14] Offset within plus minus 1500.0 mV
// [RL15] Filter constant 0.20 to 50.00 ms, default 2.00
// [RL16] Inhibit setting 3 ignores both overtravel inputs
// [RL17] Function 1: input enable, output ready
// [RL18] Gear select picks second ratio pair
// [RL19] Per-revolution resolution defaults to 10000
// [RL20] Outputs drop above threshold plus hysteresis
`timescale 1ns/100ps
`default_nettype none
module sgesc_div #(parameter int W = 32) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [W-1:0] quot
);
    logic [W:0] rem_reg;
    logic [W:0] rem_sh;
    logic [$clog2(W+1)-1:0] cnt_reg;
    assign rem_sh = {rem_reg[W-1:0], quot[W-1]};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_reg <= '0;
            quot <= '0;
            cnt_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_reg <= '0;
                quot <= dividend;
                cnt_reg <= ($clog2(W+1))'(W);
                busy <= 1'b1;
            end else if (busy) begin
                if (rem_sh >= {1'b0, divisor}) begin
                    rem_reg <= rem_sh - {1'b0, divisor};
                    quot <= {quot[W-2:0], 1'b1};
                end else begin
                    rem_reg <= rem_sh;
                    quot <= {quot[W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // sgesc_div

module sgesc_core import sgesc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_pulse,
    input wire logic cmd_dir,
    input wire logic [FREQ_W-1:0] pulse_freq_hz,
    input wire logic gear_sel,
    input wire sgesc_gear_type gear1,
    input wire sgesc_gear_type gear2,
    input wire logic [RES_W-1:0] cmd_per_rev,
    input wire logic motor_step,
    input wire logic motor_dir,
    input wire sgesc_enc_type enc_cfg,
    input wire logic signed [DEV_W-1:0] pos_deviation,
    input wire sgesc_cmp_type done_cmp,
    input wire sgesc_cmp_type near_cmp,
    input wire logic [1:0] control_mode_sel,
    input wire logic [2:0] speed_cmd_source,
    input wire sgesc_an_type an_cfg,
    input wire logic signed [AN_W-1:0] analog_chan_a,
    input wire logic signed [AN_W-1:0] analog_chan_b,
    input wire logic [1:0] sp_sel,
    input wire logic [3:0][SPD_W-1:0] internal_speed,
    input wire logic signed [SPD_W-1:0] jog_speed,
    input wire logic signed [SPD_W-1:0] demo_speed,
    input wire logic [1:0] inhibit_ignore_sel,
    input wire logic fwd_overtravel_in,
    input wire logic rev_overtravel_in,
    input wire logic di1_in,
    input wire logic [7:0] di1_func,
    input wire logic [7:0] do1_func,
    input wire logic servo_ready_in,
    output logic signed [31:0] motor_revs_reg,
    output logic [31:0] motor_speed_reg,
    output logic enc_a_reg,
    output logic enc_b_reg,
    output logic enc_z_reg,
    output logic position_done_flag,
    output logic position_near_flag,
    output logic speed_mode_reg,
    output logic signed [31:0] speed_cmd_reg,
    output logic signed [AN_W+4:0] torque_cmd_reg,
    output logic fwd_drive_prohibit,
    output logic rev_drive_prohibit,
    output logic drive_enable_in_func,
    output logic do1_out_reg
);
    // ----------------------------------------
    // Gear scaling
    // ----------------------------------------
    sgesc_gear_type gear;
    logic [RES_W-1:0] pt;
    logic signed [65:0] gdiv;
    logic signed [65:0] res_reg;
    logic signed [65:0] res_next;
    logic [63:0] spd_q;
    logic spd_busy;
    logic spd_done;
    assign gear = gear_sel ? gear2 : gear1; // RL18
    assign pt = (cmd_per_rev == '0) ? CMD_PER_REV_DEF : cmd_per_rev; // RL19
    assign gdiv = $signed({15'h0000, 51'(pt) * 51'(gear.den)});
    always_comb begin
        res_next = res_reg;
        if (cmd_pulse) begin
            res_next = cmd_dir ? res_reg - $signed({36'h0, gear.num})
                               : res_reg + $signed({36'h0, gear.num});
        end
        if (res_reg >= gdiv) begin
            res_next = res_next - gdiv;
        end else if (res_reg < 0) begin
            res_next = res_next + gdiv;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_reg <= '0;
            motor_revs_reg <= '0;
        end else begin
            res_reg <= res_next; // RL1
            if (res_reg >= gdiv) begin
                motor_revs_reg <= motor_revs_reg + 1; // RL1
            end else if (res_reg < 0) begin
                motor_revs_reg <= motor_revs_reg - 1;
            end
        end
    end
    sgesc_div #(.W(64)) u_spd_div (
        .clk(clk), .rst_n(rst_n), .start(!spd_busy),
        .dividend(64'(pulse_freq_hz) * 64'(SEC_PER_MIN) * 64'(gear.num)), // RL2
        .divisor(64'(pt) * 64'(gear.den)),
        .busy(spd_busy), .done(spd_done), .quot(spd_q)
    );
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_speed_reg <= '0;
        end else if (spd_done) begin
            motor_speed_reg <= (spd_q[63:32] != '0) ? '1 : spd_q[31:0]; // RL2
        end
    end
    // ----------------------------------------
    // Encoder emulation
    // ----------------------------------------
    logic [LINE_W+2:0] enc_acc_reg;
    logic [LINE_W+1:0] quad_pos_reg;
    logic [LINE_W+1:0] quad_max;
    logic [1:0] quad_reg;
    logic [3:0] z_cnt_reg;
    logic enc_edge;
    assign quad_max = {enc_cfg.lines, 2'b00} - 1'b1; // RL3
    assign enc_edge = (enc_acc_reg >= (LINE_W+3)'(pt));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_acc_reg <= '0;
            quad_pos_reg <= '0;
            quad_reg <= 2'b00;
            z_cnt_reg <= '0;
        end else begin
            enc_acc_reg <= enc_acc_reg
                - (enc_edge ? (LINE_W+3)'(pt) : '0)
                + (motor_step ? {1'b0, enc_cfg.lines, 2'b00} : '0); // RL3
            if (enc_edge) begin
                quad_reg <= motor_dir ? quad_reg - 1'b1 : quad_reg + 1'b1;
                if (!motor_dir) begin
                    quad_pos_reg <= (quad_pos_reg >= quad_max) ? '0 : quad_pos_reg + 1'b1;
                end else begin
                    quad_pos_reg <= (quad_pos_reg == '0) ? quad_max : quad_pos_reg - 1'b1;
                end
                if ((!motor_dir && quad_pos_reg >= quad_max)
                    || (motor_dir && quad_pos_reg == '0)) begin
                    z_cnt_reg <= enc_cfg.z_wide ? Z_EDGES_WIDE : Z_EDGES_NARROW; // RL6
                end else if (z_cnt_reg != '0) begin
                    z_cnt_reg <= z_cnt_reg - 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_a_reg <= 1'b0;
            enc_b_reg <= 1'b0;
            enc_z_reg <= 1'b0;
        end else begin
            enc_a_reg <= quad_reg[1];
            enc_b_reg <= quad_reg[1] ^ quad_reg[0] ^ enc_cfg.b_rev; // RL4
            enc_z_reg <= (z_cnt_reg != '0) ^ enc_cfg.z_rev; // RL5
        end
    end
    // ----------------------------------------
    // Positioning comparators
    // ----------------------------------------
    logic [DEV_W-1:0] dev_abs;
    assign dev_abs = pos_deviation[DEV_W-1] ? DEV_W'(-pos_deviation) : pos_deviation;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            position_done_flag <= 1'b0;
            position_near_flag <= 1'b0;
        end else begin
            if (!position_done_flag) begin
                position_done_flag <= dev_abs < done_cmp.thr; // RL7
            end else if ({1'b0, dev_abs} > {1'b0, done_cmp.thr} + done_cmp.hyst) begin
                position_done_flag <= 1'b0; // RL20
            end
            if (!position_near_flag) begin
                position_near_flag <= dev_abs < near_cmp.thr; // RL8
            end else if ({1'b0, dev_abs} > {1'b0, near_cmp.thr} + near_cmp.hyst) begin
                position_near_flag <= 1'b0; // RL20
            end
        end
    end
    // ----------------------------------------
    // Analog speed command
    // ----------------------------------------
    sgesc_an_type cfg;
    sgesc_fstate_type fs_reg;
    logic [10:0] tick_cnt_reg;
    logic signed [20:0] a_tenths;
    logic signed [20:0] a_dz;
    logic signed [20:0] b_tenths;
    logic signed [31:0] ys_reg;
    logic signed [32:0] fdiff_reg;
    logic signed [23:0] y_filt;
    logic signed [31:0] analog_rpm_reg;
    logic [31:0] f_q;
    logic [31:0] g_q;
    logic f_done;
    logic g_done;
    logic f_busy;
    logic g_busy;
    always_comb begin
        cfg = an_cfg;
        if (an_cfg.gain < GAIN_MIN || an_cfg.gain > GAIN_MAX) cfg.gain = GAIN_DEF; // RL12
        if (an_cfg.dead > DEAD_MAX) cfg.dead = DEAD_DEF; // RL13
        if (an_cfg.offs > OFFS_MAX || an_cfg.offs < -OFFS_MAX) cfg.offs = OFFS_DEF; // RL14
        if (an_cfg.tc < TC_MIN || an_cfg.tc > TC_MAX) cfg.tc = TC_DEF; // RL15
    end
    assign a_tenths = 21'(analog_chan_a) * $signed(21'(TENTHS_PER_MV)) + 21'(cfg.offs); // RL14
    assign b_tenths = 21'(analog_chan_b) * $signed(21'(TENTHS_PER_MV));
    assign a_dz = ((a_tenths < 0 ? -a_tenths : a_tenths) < 21'(cfg.dead) * 21'(TENTHS_PER_MV))
                  ? '0 : a_tenths; // RL13
    assign y_filt = ys_reg[31:8];
    sgesc_div #(.W(32)) u_filt_div (
        .clk(clk), .rst_n(rst_n), .start(fs_reg == FS_FILT && !f_busy && !f_done),
        .dividend(fdiff_reg[32] ? 32'(-fdiff_reg) : fdiff_reg[31:0]),
        .divisor({19'h00000, cfg.tc}), // RL15
        .busy(f_busy), .done(f_done), .quot(f_q)
    );
    sgesc_div #(.W(32)) u_gain_div (
        .clk(clk), .rst_n(rst_n), .start(fs_reg == FS_GAIN && !g_busy && !g_done),
        .dividend((y_filt < 0 ? 32'(-y_filt) : 32'(y_filt)) * 32'(cfg.gain)), // RL12
        .divisor(TENTHS_PER_V),
        .busy(g_busy), .done(g_done), .quot(g_q)
    );
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_reg <= FS_IDLE;
            tick_cnt_reg <= '0;
            ys_reg <= '0;
            fdiff_reg <= '0;
            analog_rpm_reg <= '0;
        end else begin
            tick_cnt_reg <= (tick_cnt_reg == 11'(FILT_TICK_CYC - 1)) ? '0 : tick_cnt_reg + 1'b1;
            case (fs_reg)
                FS_IDLE: begin
                    if (tick_cnt_reg == '0) begin
                        fdiff_reg <= (33'(cfg.chan_sel ? b_tenths : a_dz) <<< 8) - 33'(ys_reg);
                        fs_reg <= FS_FILT;
                    end
                end
                FS_FILT: begin
                    if (f_done) begin
                        ys_reg <= fdiff_reg[32] ? ys_reg - $signed(f_q) : ys_reg + $signed(f_q);
                        fs_reg <= FS_GAIN;
                    end
                end
                FS_GAIN: begin
                    if (g_done) begin
                        analog_rpm_reg <= y_filt[23] ? -$signed(g_q) : $signed(g_q);
                        fs_reg <= FS_IDLE;
                    end
                end
                default: fs_reg <= FS_IDLE;
            endcase
        end
    end
    // ----------------------------------------
    // Source select, inhibit and terminals
    // ----------------------------------------
    logic signed [31:0] cmd_sel;
    logic fwd_blk;
    logic rev_blk;
    assign fwd_blk = fwd_overtravel_in && !inhibit_ignore_sel[0]; // RL16
    assign rev_blk = rev_overtravel_in && !inhibit_ignore_sel[1]; // RL16
    always_comb begin
        case (speed_cmd_source)
            SRC_ANALOG: cmd_sel = analog_rpm_reg; // RL10
            SRC_INTERNAL: cmd_sel = 32'($signed(internal_speed[sp_sel]));
            SRC_MIXED: cmd_sel = (sp_sel == 2'h0) ? analog_rpm_reg
                                 : 32'($signed(internal_speed[sp_sel]));
            SRC_JOG: cmd_sel = 32'(jog_speed);
            SRC_DEMO: cmd_sel = 32'(demo_speed);
            SRC_RESERVED: cmd_sel = '0;
            default: cmd_sel = analog_rpm_reg; // RL10
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_mode_reg <= 1'b0;
            speed_cmd_reg <= '0;
            torque_cmd_reg <= '0;
            fwd_drive_prohibit <= 1'b0;
            rev_drive_prohibit <= 1'b0;
        end else begin
            speed_mode_reg <= control_mode_sel == MODE_SPEED; // RL9
            fwd_drive_prohibit <= fwd_blk;
            rev_drive_prohibit <= rev_blk;
            torque_cmd_reg <= cfg.chan_sel ? a_dz : b_tenths; // RL11
            if (control_mode_sel != MODE_SPEED || (fwd_blk && cmd_sel > 0)
                || (rev_blk && cmd_sel < 0)) begin
                speed_cmd_reg <= '0; // RL9
            end else begin
                speed_cmd_reg <= cmd_sel;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_enable_in_func <= 1'b0;
            do1_out_reg <= 1'b0;
        end else begin
            drive_enable_in_func <= (di1_func == DRIVE_ENABLE_IN_FUNC) && di1_in; // RL17
            case (do1_func)
                SERVO_READY_OUT_FUNC: do1_out_reg <= servo_ready_in; // RL17
                POSITION_DONE_OUT_FUNC: do1_out_reg <= position_done_flag;
                POSITION_NEAR_OUT_FUNC: do1_out_reg <= position_near_flag;
                default: do1_out_reg <= 1'b0;
            endcase
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rev_step;
        (res_reg >= gdiv) |=> (motor_revs_reg == $past(motor_revs_reg) + 1);
    endproperty
    a_rev_step: assert property (p_rev_step) else $error("revolution not counted"); // RL1
    property p_speed_load;
        spd_done && spd_q[63:32] == '0 |=> motor_speed_reg == $past(spd_q[31:0]);
    endproperty
    a_speed_load: assert property (p_speed_load) else $error("speed not loaded"); // RL2
    property p_enc_edge;
        enc_edge |=> ##1 ({enc_a_reg, enc_b_reg} != $past({enc_a_reg, enc_b_reg}));
    endproperty
    a_enc_edge: assert property (p_enc_edge) else $error("no quadrature edge"); // RL3
    property p_b_phase;
        ##1 enc_b_reg == ($past(quad_reg[1]) ^ $past(quad_reg[0]) ^ $past(enc_cfg.b_rev));
    endproperty
    a_b_phase: assert property (p_b_phase) else $error("B phase wrong"); // RL4
    property p_done_set;
        $rose(position_done_flag) |-> $past(dev_abs < done_cmp.thr);
    endproperty
    a_done_set: assert property (p_done_set) else $error("done set early"); // RL7
    property p_near_set;
        $rose(position_near_flag) |-> $past(dev_abs < near_cmp.thr);
    endproperty
    a_near_set: assert property (p_near_set) else $error("near set early"); // RL8
    property p_done_hold;
        $fell(position_done_flag)
            |-> $past({1'b0, dev_abs} > {1'b0, done_cmp.thr} + done_cmp.hyst);
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done dropped early"); // RL20
    property p_mode_zero;
        control_mode_sel != MODE_SPEED |=> speed_cmd_reg == 0 && !speed_mode_reg;
    endproperty
    a_mode_zero: assert property (p_mode_zero) else $error("speed cmd outside mode"); // RL9
    property p_ignore;
        inhibit_ignore_sel == INHIBIT_IGNORE_ALL |=> !fwd_drive_prohibit && !rev_drive_prohibit;
    endproperty
    a_ignore: assert property (p_ignore) else $error("inhibit not ignored"); // RL16
    c_rev: cover property (res_reg >= gdiv ##1 spd_done);
    c_z: cover property ($rose(enc_z_reg ^ enc_cfg.z_rev));
    c_done_cycle: cover property ($rose(position_done_flag) ##[1:50] $fell(position_done_flag));
    c_analog: cover property (fs_reg == FS_GAIN && g_done);
endmodule // sgesc_core
`default_nettype wire

// File: sgesc_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sgesc_ctrl_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [15:0] n_req,
    input wire logic enc_a,
    output logic cmd_pulse,
    output logic [15:0] a_edges
);
    logic [15:0] left_reg;
    logic a_prev;
    // ----------------------------------------
    // Pulse burst, back to back, off the falling edge
    // ----------------------------------------
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_reg <= 16'h0000;
            cmd_pulse <= 1'b0;
        end else if (go) begin
            left_reg <= n_req - 16'h0001;
            cmd_pulse <= 1'b1;
        end else begin
            cmd_pulse <= (left_reg != 16'h0000);
            left_reg <= (left_reg != 16'h0000) ? left_reg - 16'h0001 : left_reg;
        end
    end
    // ----------------------------------------
    // Encoder A transition counter
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_prev <= 1'b0;
            a_edges <= 16'h0000;
        end else begin
            a_prev <= enc_a;
            a_edges <= a_edges + 16'(enc_a ^ a_prev);
        end
    end
endmodule // sgesc_ctrl_model
`default_nettype wire

// File: sgesc_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sgesc_core_bench import sgesc_pkg::*;;
    logic clk, rst_n, cmd_pulse, cmd_dir, gear_sel, motor_step, motor_dir, go;
    logic [FREQ_W-1:0] pulse_freq_hz;
    sgesc_gear_type gear1, gear2;
    logic [RES_W-1:0] cmd_per_rev;
    sgesc_enc_type enc_cfg;
    logic signed [DEV_W-1:0] pos_deviation;
    sgesc_cmp_type done_cmp, near_cmp;
    logic [1:0] control_mode_sel, sp_sel, inhibit_ignore_sel;
    logic [2:0] speed_cmd_source;
    sgesc_an_type an_cfg;
    logic signed [AN_W-1:0] analog_chan_a, analog_chan_b;
    logic [3:0][SPD_W-1:0] internal_speed;
    logic signed [SPD_W-1:0] jog_speed, demo_speed;
    logic fwd_overtravel_in, rev_overtravel_in, di1_in, servo_ready_in;
    logic [7:0] di1_func, do1_func;
    logic signed [31:0] motor_revs_reg, speed_cmd_reg;
    logic [31:0] motor_speed_reg;
    logic enc_a_reg, enc_b_reg, enc_z_reg, position_done_flag, position_near_flag;
    logic speed_mode_reg, fwd_drive_prohibit, rev_drive_prohibit, drive_enable_in_func;
    logic do1_out_reg;
    logic signed [AN_W+4:0] torque_cmd_reg;
    logic [15:0] n_req, a_edges;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    int dv[6] = '{20, 5, 14, 16, 150, 99};
    logic [1:0] fx[6] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h0, 2'h1};
    logic [2:0] src[5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
    logic [31:0] sx[5] = '{32'd77, 32'd77, 32'd0, -32'sd33, 32'd55};
    sgesc_core dut_u (.clk(clk), .rst_n(rst_n), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
        .pulse_freq_hz(pulse_freq_hz), .gear_sel(gear_sel), .gear1(gear1), .gear2(gear2),
        .cmd_per_rev(cmd_per_rev), .motor_step(motor_step), .motor_dir(motor_dir),
        .enc_cfg(enc_cfg), .pos_deviation(pos_deviation), .done_cmp(done_cmp),
        .near_cmp(near_cmp), .control_mode_sel(control_mode_sel),
        .speed_cmd_source(speed_cmd_source), .an_cfg(an_cfg), .analog_chan_a(analog_chan_a),
        .analog_chan_b(analog_chan_b), .sp_sel(sp_sel), .internal_speed(internal_speed),
        .jog_speed(jog_speed), .demo_speed(demo_speed), .inhibit_ignore_sel(inhibit_ignore_sel),
        .fwd_overtravel_in(fwd_overtravel_in), .rev_overtravel_in(rev_overtravel_in),
        .di1_in(di1_in), .di1_func(di1_func), .do1_func(do1_func),
        .servo_ready_in(servo_ready_in), .motor_revs_reg(motor_revs_reg),
        .motor_speed_reg(motor_speed_reg), .enc_a_reg(enc_a_reg), .enc_b_reg(enc_b_reg),
        .enc_z_reg(enc_z_reg), .position_done_flag(position_done_flag),
        .position_near_flag(position_near_flag), .speed_mode_reg(speed_mode_reg),
        .speed_cmd_reg(speed_cmd_reg), .torque_cmd_reg(torque_cmd_reg),
        .fwd_drive_prohibit(fwd_drive_prohibit), .rev_drive_prohibit(rev_drive_prohibit),
        .drive_enable_in_func(drive_enable_in_func), .do1_out_reg(do1_out_reg));
    sgesc_ctrl_model ctrl_u (.clk(clk), .rst_n(rst_n), .go(go), .n_req(n_req),
        .enc_a(enc_a_reg), .cmd_pulse(cmd_pulse), .a_edges(a_edges));
    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic step(input int n);
        repeat (n) begin
            motor_step <= 1'b1;
            cyc(1);
            motor_step <= 1'b0;
            cyc(6);
        end
    endtask
    task automatic burst(input logic [15:0] n);
        n_req <= n;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(int'(n) + 8);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {rst_n, cmd_dir, gear_sel, motor_step, motor_dir, go, pulse_freq_hz, n_req} = '0;
        {control_mode_sel, sp_sel, inhibit_ignore_sel, speed_cmd_source, an_cfg} = '0;
        {analog_chan_a, jog_speed, demo_speed, fwd_overtravel_in, rev_overtravel_in} = '0;
        {di1_in, di1_func, do1_func, servo_ready_in, pos_deviation} = '0;
        gear1 = '{30'h5, 30'h4};
        gear2 = '{30'h1, 30'h1};
        cmd_per_rev = 21'h64;
        enc_cfg = '{21'h19, 1'b0, 1'b1, 1'b0};
        done_cmp = '{32'ha, 16'h5};
        near_cmp = '{32'h64, 16'h0};
        analog_chan_b = 16'sh7;
        internal_speed = {16'h0, 16'h4d, 16'h0, 16'h0};
        cyc(6);
        rst_n <= 1'b1;
        cyc(3);
        chk(enc_z_reg, 1);
        burst(16'd161);
        chk(motor_revs_reg, 2);
        gear_sel <= 1'b1;
        burst(16'd100);
        chk(motor_revs_reg, 3);
        cmd_dir <= 1'b1;
        burst(16'd105);
        chk(motor_revs_reg, 2);
        $display("test gear done");
        step(1);
        chk({enc_a_reg, enc_b_reg}, 2'b01);
        step(4);
        chk(a_edges, 2);
        enc_cfg.b_rev <= 1'b1;
        cyc(4);
        chk(enc_b_reg, 0);
        {motor_dir, enc_cfg.z_wide} <= 2'b11;
        step(6);
        chk(enc_z_reg, 0);
        step(7);
        chk(enc_z_reg, 0);
        step(1);
        chk(enc_z_reg, 1);
        $display("test encoder done");
        gear_sel <= 1'b0;
        gear1 <= '{30'h3, 30'h1};
        cmd_per_rev <= '0;
        pulse_freq_hz <= 24'd100000;
        cyc(300);
        chk(motor_speed_reg, 1800);
        do1_func <= POSITION_DONE_OUT_FUNC;
        for (int i = 0; i < 6; i++) begin
            pos_deviation <= dv[i];
            cyc(3);
            chk({position_done_flag, position_near_flag}, fx[i]);
            chk(do1_out_reg, fx[i][1]);
        end
        $display("test position done");
        control_mode_sel <= MODE_SPEED;
        sp_sel <= 2'h2;
        jog_speed <= -16'sd33;
        demo_speed <= 16'sd55;
        for (int i = 0; i < 5; i++) begin
            speed_cmd_source <= src[i];
            cyc(3);
            chk(speed_cmd_reg, sx[i]);
        end
        chk(speed_mode_reg, 1);
        chk(torque_cmd_reg, 70);
        {fwd_overtravel_in, rev_overtravel_in, di1_in, servo_ready_in} <= 4'hf;
        {di1_func, do1_func} <= {DRIVE_ENABLE_IN_FUNC, SERVO_READY_OUT_FUNC};
        cyc(3);
        chk({fwd_drive_prohibit, rev_drive_prohibit}, 2'b11);
        chk(speed_cmd_reg, 0);
        chk({drive_enable_in_func, do1_out_reg}, 2'b11);
        inhibit_ignore_sel <= INHIBIT_IGNORE_ALL;
        cyc(3);
        chk({fwd_drive_prohibit, rev_drive_prohibit}, 2'b00);
        chk(speed_cmd_reg, 55);
        $display("test speed and io done");
        summarize();
    end
endmodule // sgesc_core_bench
`default_nettype wire
